/* File: core/usb_device_interrupt_unit.sv */
// Interrupt, event flag and endpoint register unit of the USB device controller
// How it works
// - Every interrupt leaves as a high-then-low pulse on wake or event line.
// - Suspended controller resumes on control bit 6 or host resume request.
// - After either resume path completes, one wake pulse is emitted.
// - Event line merges twelve bulk requests and five bus event requests.
// - Clearing a flag with others pending fires a new pulse for the top one.
// - Simultaneous requests are prioritised; vector 0x00 to 0x10 for bus events.
// - Endpoint vectors run 0x18 to 0x44, IN then OUT, step four.
// - Bulk IN windows of 64 bytes descend by 128 from endpoint 0.
// - Bulk OUT windows sit right below each IN window.
// - Iso OUT and iso IN data each have one FIFO port address.
// - Iso OUT received count reads as high byte then low byte.
// - Iso error register refreshes each frame start; bit 0 flags OUT errors.
// - Error bit means CRC fault; received bytes still readable.
// - Zero-length bit set when previous frame had empty iso OUT packet.
// - IN done bit sets on acknowledged send; writing one clears it.
// - OUT done bit sets on error-free receive; writing one clears it.
// - Bus event bits: 4 reset, 3 suspend, 2 setup token, 1 frame, 0 setup data.
// - Bus event bits clear by writing one; upper three bits written zero.
module usb_device_interrupt_unit
    import usb_irq_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [15:0] cpuAddr,
    input wire logic cpuWrite,
    input wire logic cpuRead,
    input wire logic [7:0] cpuWriteData,
    output logic [7:0] cpuReadData,
    input wire logic [5:0] inAcked,
    input wire logic [5:0] outReceived,
    input wire bus_event_s busEvent,
    input wire iso_packet_s isoPacket,
    input wire logic [7:0] isoOutFifoData,
    input wire logic wakeupBit,
    input wire logic hostResume,
    output logic wake_pulse_line,
    output logic eventPulse,
    output logic [7:0] vectorCode,
    output logic suspended,
    output logic isoOutPop,
    output logic isoInPush,
    output logic [7:0] isoInData,
    output bulk_window_s bulkWindow
);
    logic [5:0] inFlags_ff, outFlags_ff, inEnable_ff, outEnable_ff;
    logic [4:0] busFlags_ff, busEnable_ff;
    logic isoErr_ff, zeroLen_ff, frameErr_ff, frameZero_ff;
    logic [9:0] isoCount_ff, frameCount_ff;
    logic [7:0] readData_ff, vector_ff;
    logic eventPulse_ff, wakePulse_ff, suspended_ff, retrigger_ff;
    logic isoOutPop_ff, isoInPush_ff;
    logic [7:0] isoInData_ff;
    bulk_window_s window_ff, nxt_window;
    logic wrIn, wrOut, wrBus;
    logic [4:0] busSet;
    logic [NUM_SOURCES-1:0] pending;
    logic [7:0] nxt_vector;
    logic anyPending, newEvent, clearHit;

    assign busSet = {busEvent.busReset, busEvent.suspend, busEvent.setupToken,
                     busEvent.frameStart, busEvent.setupData};
    assign wrIn = cpuWrite && (cpuAddr == IN_ENDPOINT_DONE_FLAGS_ADDR);
    assign wrOut = cpuWrite && (cpuAddr == OUT_ENDPOINT_DONE_FLAGS_ADDR);
    assign wrBus = cpuWrite && (cpuAddr == BUS_EVENT_FLAGS_ADDR);

    // Set wins over a write-one clear landing in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            inFlags_ff <= FLAGS_RESET[5:0];
            outFlags_ff <= FLAGS_RESET[5:0];
            busFlags_ff <= FLAGS_RESET[4:0];
        end else begin
            inFlags_ff <= (inFlags_ff & ~(wrIn ? cpuWriteData[5:0] : 6'h00)) | inAcked;
            outFlags_ff <= (outFlags_ff & ~(wrOut ? cpuWriteData[5:0] : 6'h00))
                | outReceived;
            // Bits 7:5 are ignored on write
            busFlags_ff <= (busFlags_ff & ~(wrBus ? cpuWriteData[4:0] : 5'h00)) | busSet;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            inEnable_ff <= FLAGS_RESET[5:0];
            outEnable_ff <= FLAGS_RESET[5:0];
            busEnable_ff <= FLAGS_RESET[4:0];
        end else if (cpuWrite) begin
            if (cpuAddr == IN_ENABLE_ADDR) begin
                inEnable_ff <= cpuWriteData[5:0];
            end else if (cpuAddr == OUT_ENABLE_ADDR) begin
                outEnable_ff <= cpuWriteData[5:0];
            end else if (cpuAddr == BUS_EVENT_ENABLE_ADDR) begin
                busEnable_ff <= cpuWriteData[4:0];
            end
        end
    end

    // Source order matches vector index; slot 5 (code 0x14) is unused
    genvar ep;
    generate
        for (ep = 0; ep < NUM_BULK_EP; ep++) begin : g_src
            assign pending[6 + 2 * ep] = inFlags_ff[ep] & inEnable_ff[ep];
            assign pending[7 + 2 * ep] = outFlags_ff[ep] & outEnable_ff[ep];
        end
    endgenerate
    assign pending[5] = 1'b0;
    assign pending[4:0] = busFlags_ff & busEnable_ff;
    assign anyPending = |pending;

    always_comb begin
        nxt_vector = VECTOR_RESET;
        for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
            if (pending[i]) begin
                nxt_vector = {i[5:0], 2'b00};
            end
        end
    end

    assign newEvent = |({outReceived & outEnable_ff, inAcked & inEnable_ff}) ||
                      |(busSet & busEnable_ff);
    assign clearHit = (wrIn && |(cpuWriteData[5:0] & inFlags_ff)) ||
                      (wrOut && |(cpuWriteData[5:0] & outFlags_ff)) ||
                      (wrBus && |(cpuWriteData[4:0] & busFlags_ff));

    // A request waits in retrigger while the line is high, so none is lost
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            retrigger_ff <= 1'b0;
            eventPulse_ff <= 1'b0;
            vector_ff <= VECTOR_RESET;
        end else begin
            eventPulse_ff <= 1'b0;
            if (!eventPulse_ff && retrigger_ff && anyPending) begin
                eventPulse_ff <= 1'b1;
                vector_ff <= nxt_vector;
                retrigger_ff <= newEvent || clearHit;
            end else if (newEvent || clearHit) begin
                retrigger_ff <= 1'b1;
            end else if (!anyPending) begin
                retrigger_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            suspended_ff <= 1'b0;
            wakePulse_ff <= 1'b0;
        end else begin
            wakePulse_ff <= 1'b0;
            if (suspended_ff && (wakeupBit || hostResume)) begin
                suspended_ff <= 1'b0;
                wakePulse_ff <= 1'b1;
            end else if (busEvent.suspend) begin
                suspended_ff <= 1'b1;
            end
        end
    end

    // Packet result is held until the next frame start makes it visible
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            frameErr_ff <= 1'b0;
            frameZero_ff <= 1'b0;
            frameCount_ff <= COUNT_RESET;
            isoErr_ff <= 1'b0;
            zeroLen_ff <= 1'b0;
            isoCount_ff <= COUNT_RESET;
        end else if (busEvent.frameStart) begin
            isoErr_ff <= frameErr_ff;
            zeroLen_ff <= frameZero_ff;
            isoCount_ff <= frameCount_ff;
            frameErr_ff <= isoPacket.done && isoPacket.crcError;
            frameZero_ff <= isoPacket.done && (isoPacket.length == COUNT_RESET);
            frameCount_ff <= isoPacket.done ? isoPacket.length : COUNT_RESET;
        end else if (isoPacket.done) begin
            frameErr_ff <= isoPacket.crcError;
            frameZero_ff <= (isoPacket.length == COUNT_RESET);
            frameCount_ff <= isoPacket.length;
        end
    end

    always_comb begin
        nxt_window = '0;
        for (int e = 0; e < NUM_BULK_EP; e++) begin
            if (cpuAddr >= BULK_IN0_BASE - 16'(e) * BULK_STRIDE &&
                cpuAddr < BULK_IN0_BASE - 16'(e) * BULK_STRIDE + BULK_WINDOW_SIZE) begin
                nxt_window = '{1'b1, 1'b1, 3'(e), cpuAddr[5:0]};
            end else if (cpuAddr >= BULK_OUT0_BASE - 16'(e) * BULK_STRIDE &&
                cpuAddr < BULK_OUT0_BASE - 16'(e) * BULK_STRIDE + BULK_WINDOW_SIZE) begin
                nxt_window = '{1'b1, 1'b0, 3'(e), cpuAddr[5:0]};
            end
        end
        if (!(cpuRead || cpuWrite)) begin
            nxt_window = '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            window_ff <= '0;
            isoOutPop_ff <= 1'b0;
            isoInPush_ff <= 1'b0;
            isoInData_ff <= FLAGS_RESET;
        end else begin
            window_ff <= nxt_window;
            isoOutPop_ff <= cpuRead && (cpuAddr == ISO_OUT_FIFO_PORT_ADDR);
            isoInPush_ff <= cpuWrite && (cpuAddr == ISO_IN_FIFO_PORT_ADDR);
            if (cpuWrite && (cpuAddr == ISO_IN_FIFO_PORT_ADDR)) begin
                isoInData_ff <= cpuWriteData;
            end
        end
    end

    // Read data follows one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readData_ff <= FLAGS_RESET;
        end else if (cpuRead) begin
            if (cpuAddr == ISO_OUT_FIFO_PORT_ADDR) begin
                readData_ff <= isoOutFifoData;
            end else if (cpuAddr == ISO_OUT_COUNT_HIGH_ADDR) begin
                readData_ff <= {6'h00, isoCount_ff[9:8]};
            end else if (cpuAddr == ISO_OUT_COUNT_LOW_ADDR) begin
                readData_ff <= isoCount_ff[7:0];
            end else if (cpuAddr == ISO_CRC_ERROR_FLAGS_ADDR) begin
                readData_ff <= 8'(isoErr_ff) << ISO_CRC_ERROR_BIT;
            end else if (cpuAddr == ISO_ZERO_LENGTH_FLAGS_ADDR) begin
                readData_ff <= 8'(zeroLen_ff) << ZERO_LENGTH_BIT;
            end else if (cpuAddr == IN_ENDPOINT_DONE_FLAGS_ADDR) begin
                readData_ff <= {2'b00, inFlags_ff};
            end else if (cpuAddr == OUT_ENDPOINT_DONE_FLAGS_ADDR) begin
                readData_ff <= {2'b00, outFlags_ff};
            end else if (cpuAddr == BUS_EVENT_FLAGS_ADDR) begin
                readData_ff <= {3'b000, busFlags_ff};
            end else if (cpuAddr == IN_ENABLE_ADDR) begin
                readData_ff <= {2'b00, inEnable_ff};
            end else if (cpuAddr == OUT_ENABLE_ADDR) begin
                readData_ff <= {2'b00, outEnable_ff};
            end else if (cpuAddr == BUS_EVENT_ENABLE_ADDR) begin
                readData_ff <= {3'b000, busEnable_ff};
            end else begin
                readData_ff <= FLAGS_RESET;
            end
        end
    end

    assign cpuReadData = readData_ff;
    assign wake_pulse_line = wakePulse_ff;
    assign eventPulse = eventPulse_ff;
    assign vectorCode = vector_ff;
    assign suspended = suspended_ff;
    assign isoOutPop = isoOutPop_ff;
    assign isoInPush = isoInPush_ff;
    assign isoInData = isoInData_ff;
    assign bulkWindow = window_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_resume;
        suspended_ff && (wakeupBit || hostResume);
    endsequence

    a_event_pulse_width: assert property (eventPulse |=> !eventPulse)
        else $error("event pulse longer than one cycle");
    a_wake_pulse_width: assert property (wake_pulse_line |=> !wake_pulse_line)
        else $error("wake pulse longer than one cycle");
    a_resume_wakes: assert property (s_resume |=> wake_pulse_line && !suspended)
        else $error("resume did not give a wake pulse");
    a_wake_cause: assert property (wake_pulse_line |-> $past(suspended))
        else $error("wake pulse without prior suspend");
    a_pulse_enabled: assert property (eventPulse |-> $past(anyPending))
        else $error("pulse with nothing enabled pending");
    a_vector_top: assert property (!eventPulse && retrigger_ff && anyPending
        |=> eventPulse && vectorCode == $past(nxt_vector))
        else $error("pending request not pulsed with top vector");
    a_vector_map: assert property (pending[0] |-> nxt_vector == 8'h00)
        else $error("setup data vector wrong");
    a_ep5_out_vec: assert property (pending == 18'h20000 |-> nxt_vector == 8'h44)
        else $error("endpoint 5 OUT vector wrong");
    a_in_set_wins: assert property (inAcked[0] |=> inFlags_ff[0])
        else $error("IN done set lost");
    a_out_clear: assert property (wrOut && cpuWriteData[1] && !outReceived[1]
        |=> !outFlags_ff[1])
        else $error("OUT done flag not cleared");
    a_bus_upper_zero: assert property (cpuRead && cpuAddr == BUS_EVENT_FLAGS_ADDR
        |=> cpuReadData[7:5] == 3'b000)
        else $error("bus event upper bits not zero");
    a_iso_err_frame: assert property (busEvent.frameStart |=> isoErr_ff == $past(frameErr_ff))
        else $error("iso error not refreshed at frame start");
    a_zero_frame: assert property (busEvent.frameStart |=> zeroLen_ff == $past(frameZero_ff))
        else $error("zero length flag not refreshed");
    a_clear_rearm: assert property (clearHit |=> retrigger_ff)
        else $error("flag clear did not rearm the event line");
endmodule : usb_device_interrupt_unit

/* File: core/usb_irq_pkg.sv */
// Shared offsets, field positions, reset values and carriers of the interrupt unit
package usb_irq_pkg;
    localparam logic [15:0] ISO_OUT_FIFO_PORT_ADDR = 16'hc760;
    localparam logic [15:0] ISO_IN_FIFO_PORT_ADDR = 16'hc768;
    localparam logic [15:0] ISO_OUT_COUNT_HIGH_ADDR = 16'hc770;
    localparam logic [15:0] ISO_OUT_COUNT_LOW_ADDR = 16'hc771;
    localparam logic [15:0] ISO_CRC_ERROR_FLAGS_ADDR = 16'hc7a0;
    localparam logic [15:0] ISO_ZERO_LENGTH_FLAGS_ADDR = 16'hc7a2;
    localparam logic [15:0] IN_ENDPOINT_DONE_FLAGS_ADDR = 16'hc7a9;
    localparam logic [15:0] OUT_ENDPOINT_DONE_FLAGS_ADDR = 16'hc7aa;
    localparam logic [15:0] BUS_EVENT_FLAGS_ADDR = 16'hc7ab;
    localparam logic [15:0] IN_ENABLE_ADDR = 16'hc7ac;
    localparam logic [15:0] OUT_ENABLE_ADDR = 16'hc7ad;
    localparam logic [15:0] BUS_EVENT_ENABLE_ADDR = 16'hc7ae;
    // Bulk windows: endpoint 0 IN on top, 128-byte step downward, OUT 64 bytes below each IN
    localparam logic [15:0] BULK_IN0_BASE = 16'hc700;
    localparam logic [15:0] BULK_OUT0_BASE = 16'hc6c0;
    localparam logic [15:0] BULK_STRIDE = 16'h0080;
    localparam logic [15:0] BULK_WINDOW_SIZE = 16'h0040;
    localparam int NUM_BULK_EP = 6;
    localparam int NUM_SOURCES = 18;
    localparam int BUS_RESET_BIT = 4;
    localparam int SUSPEND_BIT = 3;
    localparam int SETUP_TOKEN_BIT = 2;
    localparam int FRAME_START_BIT = 1;
    localparam int SETUP_DATA_BIT = 0;
    localparam int ISO_CRC_ERROR_BIT = 0;
    localparam int ZERO_LENGTH_BIT = 0;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] VECTOR_RESET = 8'h00;
    localparam logic [9:0] COUNT_RESET = 10'h000;

    typedef struct packed {
        logic busReset;
        logic suspend;
        logic setupToken;
        logic frameStart;
        logic setupData;
    } bus_event_s;

    typedef struct packed {
        logic done;
        logic crcError;
        logic [9:0] length;
    } iso_packet_s;

    typedef struct packed {
        logic hit;
        logic isIn;
        logic [2:0] endpoint;
        logic [5:0] offset;
    } bulk_window_s;
endpackage : usb_irq_pkg

/* File: tb/mcu_model.sv */
// Edge-triggered microcontroller model that drives the register bus
module mcu_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic eventPulse,
    input wire logic wakePulse,
    input wire logic [7:0] vectorCode,
    input wire logic [7:0] cpuReadData,
    output logic [15:0] cpuAddr,
    output logic cpuWrite,
    output logic cpuRead,
    output logic [7:0] cpuWriteData
);
    timeunit 1ns;
    timeprecision 100ps;
    logic evPrev;
    logic wkPrev;
    logic evLatch;
    logic [7:0] lastVec;
    logic [7:0] rdata;
    int eventCount;
    int wakeCount;
    int widePulses;

    initial begin
        cpuAddr = 16'h0000;
        cpuWrite = 1'b0;
        cpuRead = 1'b0;
        cpuWriteData = 8'h00;
        evLatch = 1'b0;
        lastVec = 8'hff;
        eventCount = 0;
        wakeCount = 0;
        widePulses = 0;
    end

    // Only a rising edge is seen, so a held-high line never gives a second request
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            evPrev <= 1'b0;
            wkPrev <= 1'b0;
        end else begin
            evPrev <= eventPulse;
            wkPrev <= wakePulse;
            if (eventPulse && !evPrev) begin
                evLatch <= 1'b1;
                lastVec <= vectorCode;
                eventCount <= eventCount + 1;
            end
            if (eventPulse && evPrev) begin
                widePulses <= widePulses + 1;
            end
            if (wakePulse && !wkPrev) begin
                wakeCount <= wakeCount + 1;
            end
        end
    end

    task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        cpuAddr <= a;
        cpuWriteData <= d;
        cpuWrite <= wr;
        cpuRead <= !wr;
        @(posedge clk);
        cpuWrite <= 1'b0;
        cpuRead <= 1'b0;
        // Released lines must not keep showing the last value
        cpuAddr <= ~a;
        cpuWriteData <= ~d;
        #1;
        rdata = cpuReadData;
    endtask : access

    // Own latch is cleared before the request bit, or the follow-on pulse may be lost
    task automatic clearLatch();
        evLatch = 1'b0;
    endtask : clearLatch
endmodule : mcu_model

/* File: tb/usb_device_interrupt_unit_tb.sv */
// Self-checking bench for the USB device interrupt unit
module usb_device_interrupt_unit_tb
    import usb_irq_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk;
    logic reset_n;
    logic [15:0] cpuAddr;
    logic cpuWrite;
    logic cpuRead;
    logic [7:0] cpuWriteData;
    logic [7:0] cpuReadData;
    logic [5:0] inAcked;
    logic [5:0] outReceived;
    bus_event_s busEvent;
    iso_packet_s isoPacket;
    logic [7:0] isoOutFifoData;
    logic wakeupBit;
    logic hostResume;
    logic wake_pulse_line;
    logic eventPulse;
    logic [7:0] vectorCode;
    logic suspended;
    logic isoOutPop;
    logic isoInPush;
    logic [7:0] isoInData;
    bulk_window_s bulkWindow;
    int errors = 0;
    int testsRun = 0;

    usb_device_interrupt_unit u_usb_device_interrupt_unit (.clk(clk), .reset_n(reset_n),
        .cpuAddr(cpuAddr), .cpuWrite(cpuWrite), .cpuRead(cpuRead),
        .cpuWriteData(cpuWriteData), .cpuReadData(cpuReadData), .inAcked(inAcked),
        .outReceived(outReceived), .busEvent(busEvent), .isoPacket(isoPacket),
        .isoOutFifoData(isoOutFifoData), .wakeupBit(wakeupBit), .hostResume(hostResume),
        .wake_pulse_line(wake_pulse_line), .eventPulse(eventPulse), .vectorCode(vectorCode),
        .suspended(suspended), .isoOutPop(isoOutPop), .isoInPush(isoInPush),
        .isoInData(isoInData), .bulkWindow(bulkWindow));

    mcu_model u_mcu_model (.clk(clk), .reset_n(reset_n), .eventPulse(eventPulse),
        .wakePulse(wake_pulse_line), .vectorCode(vectorCode), .cpuReadData(cpuReadData),
        .cpuAddr(cpuAddr), .cpuWrite(cpuWrite), .cpuRead(cpuRead),
        .cpuWriteData(cpuWriteData));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic finishTest();
        $display("Comparisons %0d, mismatches %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finishTest

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        u_mcu_model.access(1'b0, a, 8'h00);
        chk({8'h00, u_mcu_model.rdata}, exp);
    endtask : rd

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        u_mcu_model.access(1'b1, a, d);
    endtask : wr

    task automatic win(input logic [15:0] a, input logic [15:0] exp);
        u_mcu_model.access(1'b0, a, 8'h00);
        chk({5'h00, bulkWindow}, exp);
    endtask : win

    // Index follows vector order: 0..4 bus events, then IN/OUT pairs from 6
    task automatic fire(input int i);
        @(posedge clk);
        if (i < 5) busEvent <= bus_event_s'(5'(1 << i));
        else if (i % 2 == 0) inAcked <= 6'(1 << ((i - 6) / 2));
        else outReceived <= 6'(1 << ((i - 6) / 2));
        @(posedge clk);
        busEvent <= '0;
        inAcked <= '0;
        outReceived <= '0;
        #1;
    endtask : fire

    task automatic service(input logic [7:0] vec, input logic [15:0] a, input logic [7:0] b);
        int n;
        n = 0;
        while (!u_mcu_model.evLatch && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({15'h0000, u_mcu_model.evLatch}, 16'h0001);
        chk({8'h00, u_mcu_model.lastVec}, {8'h00, vec});
        u_mcu_model.clearLatch();
        wr(a, b);
    endtask : service

    task automatic s_iso();
        rd(16'h0000, 16'h0000);
        @(posedge clk);
        isoPacket <= iso_packet_s'{1'b1, 1'b1, 10'h105};
        isoOutFifoData <= 8'h5a;
        @(posedge clk);
        isoPacket <= '0;
        fire(FRAME_START_BIT);
        rd(ISO_CRC_ERROR_FLAGS_ADDR, 16'h0001);
        rd(ISO_OUT_COUNT_HIGH_ADDR, 16'h0001);
        rd(ISO_OUT_COUNT_LOW_ADDR, 16'h0005);
        rd(ISO_ZERO_LENGTH_FLAGS_ADDR, 16'h0000);
        rd(ISO_OUT_FIFO_PORT_ADDR, 16'h005a);
        chk({15'h0000, isoOutPop}, 16'h0001);
        wr(ISO_IN_FIFO_PORT_ADDR, 8'ha5);
        chk({7'h00, isoInPush, isoInData}, 16'h01a5);
        // Frame flag latches even though its request is disabled
        rd(BUS_EVENT_FLAGS_ADDR, 16'h0002);
        chk(16'(u_mcu_model.eventCount), 16'h0000);
        @(posedge clk);
        isoPacket <= iso_packet_s'{1'b1, 1'b0, 10'h000};
        @(posedge clk);
        isoPacket <= '0;
        fire(FRAME_START_BIT);
        rd(ISO_ZERO_LENGTH_FLAGS_ADDR, 16'h0001);
        rd(ISO_CRC_ERROR_FLAGS_ADDR, 16'h0000);
        rd(ISO_OUT_COUNT_LOW_ADDR, 16'h0000);
    endtask : s_iso

    task automatic s_wake(input logic viaHost);
        fire(SUSPEND_BIT);
        chk({15'h0000, suspended}, 16'h0001);
        @(posedge clk);
        if (viaHost) hostResume <= 1'b1;
        else wakeupBit <= 1'b1;
        @(posedge clk);
        hostResume <= 1'b0;
        wakeupBit <= 1'b0;
        #1;
        chk({14'h0000, wake_pulse_line, suspended}, 16'h0002);
        @(posedge clk);
        #1;
        chk({15'h0000, wake_pulse_line}, 16'h0000);
    endtask : s_wake

    task automatic s_vectors();
        logic [15:0] a;
        logic [7:0] b;
        wr(BUS_EVENT_FLAGS_ADDR, 8'h1f);
        wr(IN_ENABLE_ADDR, 8'h3f);
        wr(OUT_ENABLE_ADDR, 8'h3f);
        wr(BUS_EVENT_ENABLE_ADDR, 8'h1f);
        rd(BUS_EVENT_ENABLE_ADDR, 16'h001f);
        rd(IN_ENABLE_ADDR, 16'h003f);
        rd(OUT_ENABLE_ADDR, 16'h003f);
        for (int i = 0; i < NUM_SOURCES; i++) begin
            if (i == 5) continue;
            a = i < 5 ? BUS_EVENT_FLAGS_ADDR
                : (i % 2 == 0 ? IN_ENDPOINT_DONE_FLAGS_ADDR : OUT_ENDPOINT_DONE_FLAGS_ADDR);
            b = 8'(1 << (i < 5 ? i : (i - 6) / 2));
            fire(i);
            rd(a, {8'h00, b});
            service(8'(4 * i), a, b);
            rd(a, 16'h0000);
        end
        chk(16'(u_mcu_model.eventCount), 16'h0011);
    endtask : s_vectors

    task automatic s_priority();
        @(posedge clk);
        busEvent <= bus_event_s'(5'h01);
        outReceived <= 6'h01;
        inAcked <= 6'h20;
        @(posedge clk);
        busEvent <= '0;
        outReceived <= '0;
        inAcked <= '0;
        service(8'h00, BUS_EVENT_FLAGS_ADDR, 8'h01);
        service(8'h1c, OUT_ENDPOINT_DONE_FLAGS_ADDR, 8'h01);
        service(8'h40, IN_ENDPOINT_DONE_FLAGS_ADDR, 8'h20);
        repeat (10) @(posedge clk);
        chk(16'(u_mcu_model.eventCount), 16'h0014);
        chk(16'(u_mcu_model.widePulses), 16'h0000);
    endtask : s_priority

    task automatic s_windows();
        win(16'hc683, 16'h0643);
        win(16'hc73f, 16'h063f);
        win(16'hc740, 16'h0000);
        win(16'hc6c5, 16'h0405);
        win(16'hc47f, 16'h057f);
    endtask : s_windows

    // A resume request while awake must leave the wake line quiet
    task automatic s_idle_resume();
        fire(FRAME_START_BIT);
        @(posedge clk);
        hostResume <= 1'b1;
        @(posedge clk);
        hostResume <= 1'b0;
        @(posedge clk);
        #1;
        chk({14'h0000, wake_pulse_line, suspended}, 16'h0000);
        chk(16'(u_mcu_model.wakeCount), 16'h0000);
    endtask : s_idle_resume

    initial begin
        #200us;
        errors++;
        finishTest();
    end

    initial begin
        reset_n = 1'b0;
        inAcked = '0;
        outReceived = '0;
        busEvent = '0;
        isoPacket = '0;
        isoOutFifoData = 8'h00;
        wakeupBit = 1'b0;
        hostResume = 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        s_iso();
        s_windows();
        s_idle_resume();
        s_wake(1'b1);
        s_wake(1'b0);
        chk(16'(u_mcu_model.wakeCount), 16'h0002);
        s_vectors();
        s_priority();
        finishTest();
    end
endmodule : usb_device_interrupt_unit_tb
